// *** tsca_chain.sv ***
/*
 * Register access scan chain of the trace macrocell. A debugger shifts a
 * frame through the test port into this chain; on Update-DR the frame is
 * handed to the system clock domain, where it becomes one read or write
 * strobe towards the trace registers.
 * Assumes the test controller states arrive as one-cycle levels on tck,
 * and that the trace registers answer a read in the strobe's own cycle.
 */
`timescale 1ns/1ps

`include "tsca_map.svh"

// Contract
// - Chain reachable only as test chain six.
// - Forty-bit chain: data, address, read/write flag.
// - Reads ignore data, change no register.
// - Access happens only on entering Update-DR.
module tsca_chain (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic                     tck,
    input  wire logic                     tap_reset,
    input  wire logic                     tdi,
    input  wire logic [3:0]               chain_num,
    input  wire logic                     capture_dr,
    input  wire logic                     shift_dr,
    input  wire logic                     update_dr,
    output logic                          tdo,
    output logic                          acc_wr,
    output logic                          acc_rd,
    output logic [`TSCA_ADDR_W-1:0]       acc_addr,
    output logic [`TSCA_DATA_W-1:0]       acc_wdata,
    input  wire logic [`TSCA_DATA_W-1:0]  acc_rdata
);
    import tsca_pkg::*;

    // Test clock side.
    tsca_pkg::tsca_frame_t   sr;
    tsca_pkg::tsca_frame_t   next_sr;
    logic [`TSCA_DATA_W-1:0] req_data;
    logic [`TSCA_DATA_W-1:0] next_req_data;
    logic [`TSCA_ADDR_W-1:0] req_addr;
    logic [`TSCA_ADDR_W-1:0] next_req_addr;
    logic                    req_wr;
    logic                    next_req_wr;
    logic                    req_tgl;
    logic                    next_req_tgl;
    logic [`TSCA_DATA_W-1:0] tck_rdata;
    logic [`TSCA_DATA_W-1:0] next_tck_rdata;
    logic                    ak_s1;
    logic                    ak_s2;
    logic                    ak_s3;
    logic                    sel;
    logic                    busy;
    logic                    ack_edge;
    logic                    take;

    // System clock side.
    tsca_pkg::tsca_state_t   state;
    tsca_pkg::tsca_state_t   next_state;
    logic                    next_acc_wr;
    logic                    next_acc_rd;
    logic [`TSCA_ADDR_W-1:0] next_acc_addr;
    logic [`TSCA_DATA_W-1:0] next_acc_wdata;
    logic [`TSCA_DATA_W-1:0] rd_hold;
    logic [`TSCA_DATA_W-1:0] next_rd_hold;
    logic                    ack_tgl;
    logic                    next_ack_tgl;
    logic                    rq_s1;
    logic                    rq_s2;
    logic                    rq_s3;
    logic                    req_edge;

    assign sel      = (chain_num == `TSCA_CHAIN_NUM);
    assign busy     = (req_tgl != ak_s2);
    assign ack_edge = ak_s2 ^ ak_s3;
    // An update that lands while the previous access is still in flight is
    // dropped; a debugger at normal test clock rates never sees this.
    assign take     = sel && update_dr && !busy;
    assign tdo      = sr[0];

    always_comb begin
        next_sr        = sr;
        next_req_data  = req_data;
        next_req_addr  = req_addr;
        next_req_wr    = req_wr;
        next_req_tgl   = req_tgl;
        next_tck_rdata = ack_edge ? rd_hold : tck_rdata;
        if (sel && capture_dr) begin
            // Read data from the last read access comes out in the next scan.
            next_sr = {1'h0, `TSCA_ADDR_RST, tck_rdata};
        end else if (sel && shift_dr) begin
            next_sr = {tdi, sr[`TSCA_FRAME_W-1:1]};
        end
        if (take) begin
            next_req_data = sr[`TSCA_ADDR_LSB-1:`TSCA_DATA_LSB];
            next_req_addr = sr[`TSCA_RW_BIT-1:`TSCA_ADDR_LSB];
            next_req_wr   = sr[`TSCA_RW_BIT];
            next_req_tgl  = ~req_tgl;
        end
    end

    always_ff @(posedge tck) begin
        if (tap_reset) begin
            sr        <= `TSCA_FRAME_RST;
            req_data  <= `TSCA_DATA_RST;
            req_addr  <= `TSCA_ADDR_RST;
            req_wr    <= 1'h0;
            req_tgl   <= 1'h0;
            tck_rdata <= `TSCA_DATA_RST;
            ak_s1     <= 1'h0;
            ak_s2     <= 1'h0;
            ak_s3     <= 1'h0;
        end else begin
            sr        <= next_sr;
            req_data  <= next_req_data;
            req_addr  <= next_req_addr;
            req_wr    <= next_req_wr;
            req_tgl   <= next_req_tgl;
            tck_rdata <= next_tck_rdata;
            ak_s1     <= ack_tgl;
            ak_s2     <= ak_s1;
            ak_s3     <= ak_s2;
        end
    end

    // Request fields are held still by the test clock side until the
    // acknowledge returns, so they are safe to read once the toggle lands.
    assign req_edge = rq_s2 ^ rq_s3;

    always_comb begin
        next_state     = state;
        next_acc_wr    = 1'h0;
        next_acc_rd    = 1'h0;
        next_acc_addr  = acc_addr;
        next_acc_wdata = acc_wdata;
        next_rd_hold   = rd_hold;
        next_ack_tgl   = ack_tgl;
        case (state)
            TSCA_IDLE: begin
                if (req_edge) begin
                    next_acc_wr   = (req_wr == `TSCA_RW_WRITE);
                    next_acc_rd   = (req_wr != `TSCA_RW_WRITE);
                    next_acc_addr = req_addr;
                    if (req_wr == `TSCA_RW_WRITE) begin
                        next_acc_wdata = req_data;
                    end
                    next_state = TSCA_ISSUE;
                end
            end
            TSCA_ISSUE: begin
                if (acc_rd) begin
                    next_rd_hold = acc_rdata;
                end
                next_ack_tgl = ~ack_tgl;
                next_state   = TSCA_IDLE;
            end
            default: begin
                next_state = TSCA_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state     <= TSCA_IDLE;
            acc_wr    <= 1'h0;
            acc_rd    <= 1'h0;
            acc_addr  <= `TSCA_ADDR_RST;
            acc_wdata <= `TSCA_DATA_RST;
            rd_hold   <= `TSCA_DATA_RST;
            ack_tgl   <= 1'h0;
            rq_s1     <= 1'h0;
            rq_s2     <= 1'h0;
            rq_s3     <= 1'h0;
        end else begin
            state     <= next_state;
            acc_wr    <= next_acc_wr;
            acc_rd    <= next_acc_rd;
            acc_addr  <= next_acc_addr;
            acc_wdata <= next_acc_wdata;
            rd_hold   <= next_rd_hold;
            ack_tgl   <= next_ack_tgl;
            rq_s1     <= req_tgl;
            rq_s2     <= rq_s1;
            rq_s3     <= rq_s2;
        end
    end

    sequence s_req_seen;
        (state == TSCA_IDLE) && req_edge;
    endsequence

    sequence s_issue;
        (acc_wr || acc_rd) ##1 (ack_tgl != $past(ack_tgl));
    endsequence

    property p_unselected_idle;
        @(posedge tck) disable iff (tap_reset)
        !sel |=> $stable(sr) && $stable(req_tgl);
    endproperty
    a_unselected_idle: assert property (p_unselected_idle)
        else $error("Chain changed while not selected.");

    property p_shift;
        @(posedge tck) disable iff (tap_reset)
        (sel && shift_dr && !capture_dr) |=>
            (sr == {$past(tdi), $past(sr[`TSCA_FRAME_W-1:1])});
    endproperty
    a_shift: assert property (p_shift)
        else $error("Shift did not move the forty-bit frame by one.");

    property p_field_order;
        @(posedge tck) disable iff (tap_reset)
        take |=> (req_wr == $past(sr[`TSCA_RW_BIT]))
            && (req_addr == $past(sr[`TSCA_RW_BIT-1:`TSCA_ADDR_LSB]))
            && (req_data == $past(sr[`TSCA_ADDR_LSB-1:0]));
    endproperty
    a_field_order: assert property (p_field_order)
        else $error("Frame fields latched from the wrong bits.");

    property p_update_only;
        @(posedge tck) disable iff (tap_reset)
        !take |=> $stable(req_tgl);
    endproperty
    a_update_only: assert property (p_update_only)
        else $error("Access requested outside Update-DR.");

    property p_strobe_cause;
        @(posedge clk) disable iff (srst)
        (acc_wr || acc_rd) |-> $past(state == TSCA_IDLE && req_edge);
    endproperty
    a_strobe_cause: assert property (p_strobe_cause)
        else $error("Access strobe without a handed-over update.");

    property p_flag_kind;
        @(posedge clk) disable iff (srst)
        s_req_seen |=> (acc_wr == req_wr) && (acc_rd == !req_wr)
            && (acc_addr == req_addr);
    endproperty
    a_flag_kind: assert property (p_flag_kind)
        else $error("Strobe kind or address does not match the flag.");

    property p_read_keeps;
        @(posedge clk) disable iff (srst)
        s_req_seen ##0 !req_wr |=> !acc_wr && $stable(acc_wdata);
    endproperty
    a_read_keeps: assert property (p_read_keeps)
        else $error("A read disturbed the write path.");

    property p_ack;
        @(posedge clk) disable iff (srst)
        acc_rd |-> s_issue ##0 (rd_hold == $past(acc_rdata)) ##1 !acc_rd;
    endproperty
    a_ack: assert property (p_ack)
        else $error("Read answer not held or acknowledged.");
endmodule

// *** tsca_map.svh ***
/*
 * Constants of the trace register access chain: chain number, frame
 * layout and reset values.
 * Assumes it is included by its bare name from the package and modules.
 */
`ifndef TSCA_MAP_SVH
`define TSCA_MAP_SVH

`define TSCA_CHAIN_NUM    4'h6
`define TSCA_FRAME_W      40
`define TSCA_DATA_W       32
`define TSCA_ADDR_W       7
`define TSCA_DATA_LSB     0
`define TSCA_ADDR_LSB     32
`define TSCA_RW_BIT       39
`define TSCA_RW_WRITE     1'h1
`define TSCA_FRAME_RST    40'h00_0000_0000
`define TSCA_DATA_RST     32'h0000_0000
`define TSCA_ADDR_RST     7'h00

`endif

// *** tsca_pkg.sv ***
/*
 * Types shared by the trace register access chain.
 * Assumes tsca_map.svh is on the include path.
 */
package tsca_pkg;
    `include "tsca_map.svh"

    typedef enum logic {
        TSCA_IDLE,
        TSCA_ISSUE
    } tsca_state_t;

    typedef logic [`TSCA_FRAME_W-1:0] tsca_frame_t;
endpackage

// *** tsca_dbg.sv ***
/*
 * Debugger model: drives the test controller states and serial data of
 * the register access chain; its test clock runs only during reset and frames.
 * Assumes the bench calls its tasks one at a time.
 */
`timescale 1ns/1ps
module tsca_dbg (
    output logic       tck,
    output logic       tap_reset,
    output logic       tdi,
    output logic [3:0] chain_num,
    output logic       capture_dr,
    output logic       shift_dr,
    output logic       update_dr,
    input  wire logic  tdo
);
    initial begin
        {tck, tap_reset, tdi, capture_dr, shift_dr, update_dr} = '0;
        chain_num = 4'h0;
    end
    task automatic tick(input int n);
        repeat (n) begin
            #6 tck = 1'h1;
            #6 tck = 1'h0;
        end
    endtask
    task automatic treset();
        tap_reset = 1'h1;
        tick(3);
        tap_reset = 1'h0;
        tick(1);
    endtask
    // Idle ticks after update give the acknowledge time to come back.
    task automatic scan(input logic [39:0] f, input logic [3:0] ch,
                        output logic [39:0] got);
        chain_num = ch;
        capture_dr = 1'h1;
        tick(1);
        capture_dr = 1'h0;
        shift_dr = 1'h1;
        for (int i = 0; i < 40; i++) begin
            got[i] = tdo;
            tdi = f[i];
            tick(1);
        end
        shift_dr = 1'h0;
        tdi = ~tdi;
        update_dr = 1'h1;
        tick(1);
        update_dr = 1'h0;
        tick(10);
    endtask
endmodule

// *** tsca_chain_tb.sv ***
/*
 * Self-checking bench of the register access chain; the bench plays
 * the trace registers, the debugger model the test side.
 * Assumes tsca_pkg, tsca_chain and tsca_dbg are compiled first.
 */
`timescale 1ns/1ps
module tsca_chain_tb;
    import tsca_pkg::*;
    logic        clk, srst, tck, tap_reset, tdi, tdo;
    logic        capture_dr, shift_dr, update_dr, acc_wr, acc_rd;
    logic [3:0]  chain_num;
    logic [6:0]  acc_addr;
    logic [31:0] acc_wdata, acc_rdata;
    tsca_frame_t got;
    int          fail_count, compares, cycles, n_wr, n_rd;

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    tsca_dbg DBG (.tck, .tap_reset, .tdi, .chain_num, .capture_dr,
                  .shift_dr, .update_dr, .tdo);
    tsca_chain DUT (.clk, .srst, .tck, .tap_reset, .tdi, .chain_num,
                    .capture_dr, .shift_dr, .update_dr, .tdo, .acc_wr,
                    .acc_rd, .acc_addr, .acc_wdata, .acc_rdata);

    always @(posedge clk) begin
        cycles++;
        if (acc_wr === 1'h1) n_wr++;
        if (acc_rd === 1'h1) n_rd++;
        // A strobe while bits still move would act on a half frame.
        if ((acc_wr | acc_rd) === 1'h1 && shift_dr === 1'h1) begin
            fail_count++;
            $display("CHECK FAILED strobe during shift expected 0 seen 1");
        end
        if (cycles == 20000) begin
            fail_count++;
            $display("CHECK FAILED timeout expected done seen running");
            summarize();
        end
    end

    task automatic check(input string nm, input logic [39:0] exp, act);
        compares++;
        if (act !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, act);
        end
    endtask
    task automatic t_write();
        logic [39:0] f [2];
        f[0] = {1'h1, 7'h7f, 32'ha5c3_0f96};
        f[1] = {1'h1, 7'h00, 32'h5a3c_f069};
        foreach (f[i]) begin
            n_wr = 0;
            n_rd = 0;
            DBG.scan(f[i], 4'h6, got);
            check("capture", 40'h00_0000_0000, got);
            check("writes", 1, n_wr);
            check("reads", 0, n_rd);
            check("addr", f[i][38:32], acc_addr);
            check("wdata", f[i][31:0], acc_wdata);
        end
        $display("write test done");
    endtask
    task automatic t_read();
        @(posedge clk);
        acc_rdata <= 32'h1234_abcd;
        n_wr = 0;
        n_rd = 0;
        DBG.scan({1'h0, 7'h11, 32'hffff_ffff}, 4'h6, got);
        check("reads", 1, n_rd);
        check("writes", 0, n_wr);
        check("addr", 7'h11, acc_addr);
        check("wdata kept", 32'h5a3c_f069, acc_wdata);
        DBG.scan({1'h0, 7'h22, 32'h0000_0000}, 4'h6, got);
        check("read data", 40'h00_1234_abcd, got);
        $display("read test done");
    endtask
    task automatic t_chain();
        n_wr = 0;
        n_rd = 0;
        DBG.scan({1'h1, 7'h33, 32'h0f0f_0f0f}, 4'h5, got);
        check("strobes", 0, n_wr + n_rd);
        check("addr kept", 7'h22, acc_addr);
        check("wdata kept", 32'h5a3c_f069, acc_wdata);
        $display("chain select test done");
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        srst = 1'h1;
        acc_rdata = 32'h0000_0000;
        {fail_count, compares, cycles, n_wr, n_rd} = '0;
        repeat (3) @(posedge clk);
        srst <= 1'h0;
        DBG.treset();
        check("reset addr", 7'h00, acc_addr);
        check("reset tdo", 40'h00_0000_0000, tdo);
        t_write();
        t_read();
        t_chain();
        summarize();
    end
endmodule
